// ==== inc/dtx_pkg.sv ====
// Constants and types of the data-transfer executor.
// Assumes an AXI4-Lite master on the system clock.
// Notes on behaviour
// RL1: Zero flag is set on an all-zero result of an affecting operation, else cleared.
// RL2: Carry flag holds unsigned carry of add or borrow of subtract.
// RL3: Half-carry flag is set on carry out of the low nibble.
// RL4: Overflow flag marks a result outside signed byte range.
// RL5: Word operands accept only addresses zero to 0x1F.
// RL6: Bit-addressed memory operations accept only byte addresses zero to 0xF.
// RL7: Immediate move loads the constant into the accumulator, flags unchanged.
// RL8: Accumulator-to-memory move writes the byte, flags unchanged.
// RL9: Memory-to-accumulator move loads the byte and updates only zero.
// RL10: IO-to-accumulator move loads the IO register and updates only zero.
// RL11: Accumulator-to-IO move writes the IO register, flags unchanged.
// RL12: Timer read copies the whole 16-bit count into a memory word.
// RL13: Timer write loads the 16-bit count from a memory word.
// RL14: Indirect load reads the byte a word pointer names; two cycles, no flags.
// RL15: Software keeps the pointer high byte zero, address in low byte.
// RL16: Timer mode bit 5 set enables counting, cleared stops it.
// RL17: Indirect store writes the accumulator through a word pointer; two cycles, no flags.
// RL18: Push stores accumulator and flags at the stack pointer, adds 2; pop reverses.
// RL19: Word operands keep low byte at the even address, high byte next.
package dtx_pkg;
   localparam int         AXI_AW     = 4;
   localparam logic [3:0] REG_CMD    = 4'h0;
   localparam logic [3:0] REG_STAT   = 4'h4;
   localparam logic [3:0] REG_TMR    = 4'h8;
   localparam logic [3:0] REG_SP     = 4'hc;
   localparam int         STAT_BUSY  = 16;
   localparam int         STAT_ERR   = 17;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;
   localparam logic [7:0] WORD_MAX   = 8'h1f;
   localparam logic [7:0] BIT_MAX    = 8'h0f;
   localparam int         MEM_DEPTH  = 64;
   localparam int         IO_DEPTH   = 8;
   localparam logic [2:0] IO_TMODE   = 3'h7;
   localparam int         TMR_EN_BIT = 5;
   localparam logic [7:0] SP_RST     = 8'h20;
   localparam logic [7:0] ACC_RST    = 8'h00;
   localparam logic [15:0] TMR_RST   = 16'h0000;
   localparam logic [3:0] OP_NOP     = 4'h0;
   localparam logic [3:0] OP_MOV_AI  = 4'h1;
   localparam logic [3:0] OP_MOV_MA  = 4'h2;
   localparam logic [3:0] OP_MOV_AM  = 4'h3;
   localparam logic [3:0] OP_MOV_AIO = 4'h4;
   localparam logic [3:0] OP_MOV_IOA = 4'h5;
   localparam logic [3:0] OP_TRD     = 4'h6;
   localparam logic [3:0] OP_TWR     = 4'h7;
   localparam logic [3:0] OP_IDX_LD  = 4'h8;
   localparam logic [3:0] OP_IDX_ST  = 4'h9;
   localparam logic [3:0] OP_PUSH    = 4'ha;
   localparam logic [3:0] OP_POP     = 4'hb;
   localparam logic [3:0] OP_SET1    = 4'hc;
   localparam logic [3:0] OP_SET0    = 4'hd;

   typedef struct packed {
      logic       overflow_flag;
      logic       half_carry_flag;
      logic       carry;
      logic       zero;
   } dtx_flags_t;

   typedef struct packed {
      logic [4:0] rsv;
      logic [2:0] bitn;
      logic [7:0] imm;
      logic [7:0] addr;
      logic [3:0] rsv2;
      logic [3:0] op;
   } dtx_cmd_t;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_IDX2} dtx_state_t;
endpackage

// ==== design/dtx_exec.sv ====
// Data-transfer instruction executor with AXI4-Lite command port.
// Assumes one write and one read outstanding; data RAM and IO are local flops.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dtx_exec import dtx_pkg::*; (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // AXI4-Lite write
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   logic              rst_q1, rst_q2;
   logic              aw_have_q, w_have_q;
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   dtx_state_t        state_q;
   dtx_cmd_t          cmd_q;
   logic [7:0]        ptr_q;
   logic [7:0]        accumulator_reg_q;
   dtx_flags_t        flags_q;
   logic [7:0]        stack_ptr_q;
   logic [15:0]       wide_timer_q;
   logic              err_q;
   logic [7:0]        mem_q [MEM_DEPTH];
   logic [7:0]        io_q [IO_DEPTH];
   logic              wr_go, cmd_wr, busy, ex, bad, word_ok, mem_ok, bit_ok;
   logic [5:0]        ma, ma_hi, sp_i, sp_p1, pop_lo, pop_hi, ptr_i;
   logic [2:0]        ia;
   logic [31:0]       rd_mux;
   logic [1:0]        rd_resp;
   logic [7:0]        low_byte_sel, high_byte_sel;

   // Reset release synchroniser
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end

   assign busy    = state_q != ST_IDLE;
   assign ex      = state_q == ST_EXEC;
   assign ma      = cmd_q.addr[5:0];
   assign ma_hi   = {ma[5:1], 1'b1};
   assign ia      = cmd_q.addr[2:0];
   assign sp_i    = stack_ptr_q[5:0];
   assign sp_p1   = 6'(sp_i + 6'h1);
   assign pop_lo  = 6'(sp_i - 6'h2);
   assign pop_hi  = 6'(sp_i - 6'h1);
   assign ptr_i   = ptr_q[5:0];
   assign low_byte_sel  = mem_q[ma];
   assign high_byte_sel = mem_q[ma_hi];
   assign word_ok = (cmd_q.addr <= WORD_MAX) && !cmd_q.addr[0];                   // [RL5] [RL19]
   assign bit_ok  = cmd_q.addr <= BIT_MAX;                                        // [RL6]
   assign mem_ok  = cmd_q.addr < 8'(MEM_DEPTH);

   // Illegal operand or opcode: no effect, error flag raised
   always_comb begin
      case (cmd_q.op)
         OP_NOP, OP_MOV_AI, OP_MOV_AIO, OP_MOV_IOA, OP_PUSH, OP_POP: bad = 1'b0;
         OP_MOV_MA, OP_MOV_AM:                  bad = !mem_ok;
         OP_TRD, OP_TWR, OP_IDX_LD, OP_IDX_ST:  bad = !word_ok;                  // [RL5]
         OP_SET1, OP_SET0:                      bad = !bit_ok;                   // [RL6]
         default:                               bad = 1'b1;
      endcase
   end

   // AXI write channel
   assign wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
   assign cmd_wr = wr_go && awaddr_q == REG_CMD && !busy && wstrb_q != 4'h0;
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= '0;
         wdata_q       <= '0;
         wstrb_q       <= '0;
      end else begin
         if (s_axi_awready && s_axi_awvalid) begin
            aw_have_q     <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            w_have_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
               REG_CMD:          s_axi_bresp <= busy ? RESP_SLV : RESP_OKAY;
               REG_STAT, REG_SP: s_axi_bresp <= RESP_OKAY;
               default:          s_axi_bresp <= RESP_SLV;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // AXI read channel
   always_comb begin
      rd_resp = RESP_OKAY;
      case (s_axi_araddr)
         REG_CMD:  rd_mux = cmd_q;
         REG_STAT: rd_mux = {14'h0, err_q, busy, 4'h0, flags_q, accumulator_reg_q};
         REG_TMR:  rd_mux = {16'h0, wide_timer_q};
         REG_SP:   rd_mux = {24'h0, stack_ptr_q};
         default: begin
            rd_mux  = 32'h0;
            rd_resp = RESP_SLV;
         end
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_resp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Sequencer
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         state_q <= ST_IDLE;
         cmd_q   <= '0;
         ptr_q   <= '0;
      end else begin
         case (state_q)
            ST_IDLE: if (cmd_wr) begin
               cmd_q   <= wdata_q;
               state_q <= ST_EXEC;
            end
            ST_EXEC: if (!bad && (cmd_q.op == OP_IDX_LD || cmd_q.op == OP_IDX_ST)) begin
               ptr_q   <= low_byte_sel;                                           // [RL15] [RL19]
               state_q <= ST_IDX2;                                                // [RL14] [RL17]
            end else begin
               state_q <= ST_IDLE;
            end
            ST_IDX2: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Error flag; a new error wins over a clear
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         err_q <= 1'b0;
      end else if (ex && bad) begin
         err_q <= 1'b1;
      end else if (wr_go && awaddr_q == REG_STAT && wdata_q[STAT_ERR] && wstrb_q[2]) begin
         err_q <= 1'b0;
      end
   end

   // Accumulator and flags
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         accumulator_reg_q <= ACC_RST;
         flags_q           <= '0;
      end else if (ex && !bad) begin
         case (cmd_q.op)
            OP_MOV_AI:  accumulator_reg_q <= cmd_q.imm;                           // [RL7]
            OP_MOV_AM: begin
               accumulator_reg_q <= mem_q[ma];                                    // [RL9]
               flags_q.zero      <= mem_q[ma] == 8'h00;                           // [RL1]
            end
            OP_MOV_AIO: begin
               accumulator_reg_q <= io_q[ia];                                     // [RL10]
               flags_q.zero      <= io_q[ia] == 8'h00;                            // [RL1]
            end
            OP_POP: {flags_q, accumulator_reg_q} <= {mem_q[pop_hi][3:0], mem_q[pop_lo]}; // [RL18] [RL2] [RL3] [RL4]
            default: ;
         endcase
      end else if (state_q == ST_IDX2 && cmd_q.op == OP_IDX_LD) begin
         accumulator_reg_q <= mem_q[ptr_i];                                       // [RL14]
      end
   end

   // Stack pointer
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         stack_ptr_q <= SP_RST;
      end else if (ex && !bad && cmd_q.op == OP_PUSH) begin
         stack_ptr_q <= 8'(stack_ptr_q + 8'h2);                                   // [RL18]
      end else if (ex && !bad && cmd_q.op == OP_POP) begin
         stack_ptr_q <= 8'(stack_ptr_q - 8'h2);                                   // [RL18]
      end else if (wr_go && awaddr_q == REG_SP && !busy && wstrb_q[0]) begin
         stack_ptr_q <= wdata_q[7:0];
      end
   end

   // Data RAM
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (ex && !bad) begin
         case (cmd_q.op)
            OP_MOV_MA: mem_q[ma] <= accumulator_reg_q;                            // [RL8]
            OP_TRD: begin
               mem_q[ma]    <= wide_timer_q[7:0];                                 // [RL12] [RL19]
               mem_q[ma_hi] <= wide_timer_q[15:8];
            end
            OP_SET1: mem_q[ma][cmd_q.bitn] <= 1'b1;                               // [RL6]
            OP_SET0: mem_q[ma][cmd_q.bitn] <= 1'b0;                               // [RL6]
            OP_PUSH: begin
               mem_q[sp_i]  <= accumulator_reg_q;                                 // [RL18]
               mem_q[sp_p1] <= {4'h0, flags_q};
            end
            default: ;
         endcase
      end else if (state_q == ST_IDX2 && cmd_q.op == OP_IDX_ST) begin
         mem_q[ptr_i] <= accumulator_reg_q;                                       // [RL17]
      end
   end

   // IO register space; slot IO_TMODE is the wide_timer_mode_reg
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         for (int i = 0; i < IO_DEPTH; i++) begin
            io_q[i] <= 8'h00;
         end
      end else if (ex && !bad && cmd_q.op == OP_MOV_IOA) begin
         io_q[ia] <= accumulator_reg_q;                                           // [RL11]
      end
   end

   // Wide timer; a load wins over counting
   always_ff @(posedge sys_clk or negedge rst_q2) begin
      if (!rst_q2) begin
         wide_timer_q <= TMR_RST;
      end else if (ex && !bad && cmd_q.op == OP_TWR) begin
         wide_timer_q <= {high_byte_sel, low_byte_sel};                           // [RL13] [RL19]
      end else if (io_q[IO_TMODE][TMR_EN_BIT]) begin
         wide_timer_q <= 16'(wide_timer_q + 16'h1);                               // [RL16]
      end
   end

   sequence s_idx_tail;
      state_q == ST_IDX2 ##1 state_q == ST_IDLE;
   endsequence
   property p_imm;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && !bad && cmd_q.op == OP_MOV_AI |=> accumulator_reg_q == $past(cmd_q.imm) && $stable(flags_q);
   endproperty
   a_imm: assert property (p_imm) else $error("Immediate move wrong"); // [RL7]
   property p_mem_ld;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && !bad && cmd_q.op == OP_MOV_AM |=> flags_q.zero == (accumulator_reg_q == 8'h00)
         && flags_q[3:1] == $past(flags_q[3:1]);
   endproperty
   a_mem_ld: assert property (p_mem_ld) else $error("Memory load flags wrong"); // [RL9]
   property p_io_ld;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && !bad && cmd_q.op == OP_MOV_AIO |=> accumulator_reg_q == io_q[$past(ia)]
         && flags_q.zero == (accumulator_reg_q == 8'h00);
   endproperty
   a_io_ld: assert property (p_io_ld) else $error("IO load wrong"); // [RL10]
   property p_word_rng;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && cmd_q.op == OP_TWR && cmd_q.addr > WORD_MAX |=> err_q
         && wide_timer_q == 16'($past(wide_timer_q) + {15'h0, $past(io_q[IO_TMODE][TMR_EN_BIT])});
   endproperty
   a_word_rng: assert property (p_word_rng) else $error("Word range not refused"); // [RL5]
   property p_bit_rng;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && cmd_q.op == OP_SET1 && cmd_q.addr > BIT_MAX |=> err_q;
   endproperty
   a_bit_rng: assert property (p_bit_rng) else $error("Bit range not refused"); // [RL6]
   property p_idx;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && !bad && cmd_q.op == OP_IDX_LD |=> s_idx_tail ##0 accumulator_reg_q == mem_q[$past(ptr_i)]
         && $stable(flags_q);
   endproperty
   a_idx: assert property (p_idx) else $error("Indirect load wrong"); // [RL14]
   property p_push;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && !bad && cmd_q.op == OP_PUSH |=> stack_ptr_q == 8'($past(stack_ptr_q) + 8'h2)
         && mem_q[$past(sp_i)] == accumulator_reg_q;
   endproperty
   a_push: assert property (p_push) else $error("Push wrong"); // [RL18]
   property p_tmr_stop;
      @(posedge sys_clk) disable iff (!rst_q2)
      !io_q[IO_TMODE][TMR_EN_BIT] && !(ex && cmd_q.op == OP_TWR) |=> $stable(wide_timer_q);
   endproperty
   a_tmr_stop: assert property (p_tmr_stop) else $error("Timer moved while stopped"); // [RL16]
   property p_trd;
      @(posedge sys_clk) disable iff (!rst_q2)
      ex && !bad && cmd_q.op == OP_TRD |=> {mem_q[ma_hi], mem_q[ma]} == $past(wide_timer_q);
   endproperty
   a_trd: assert property (p_trd) else $error("Timer read wrong"); // [RL12]
endmodule // dtx_exec

// ==== verification/dtx_axi_master.sv ====
// AXI4-Lite master model standing in for the software side of the executor.
// Assumes it shares sys_clk with the executor; the bench drives it through its tasks.
`timescale 1ns/1ps
module dtx_axi_master import dtx_pkg::*; (
   // Clock
   input  wire logic              sys_clk,
   // Write channels
   output logic [AXI_AW-1:0]      s_axi_awaddr,
   output logic                   s_axi_awvalid,
   input  wire logic              s_axi_awready,
   output logic [31:0]            s_axi_wdata,
   output logic [3:0]             s_axi_wstrb,
   output logic                   s_axi_wvalid,
   input  wire logic              s_axi_wready,
   input  wire logic [1:0]        s_axi_bresp,
   input  wire logic              s_axi_bvalid,
   output logic                   s_axi_bready,
   // Read channels
   output logic [AXI_AW-1:0]      s_axi_araddr,
   output logic                   s_axi_arvalid,
   input  wire logic              s_axi_arready,
   input  wire logic [31:0]       s_axi_rdata,
   input  wire logic [1:0]        s_axi_rresp,
   input  wire logic              s_axi_rvalid,
   output logic                   s_axi_rready
);
   int hang_count = 0;

   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      r = 2'h3;
      @(posedge sys_clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (int i = 0; i < 200; i++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
      end
      hang_count++;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
   endtask

   task automatic rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
      d = '0;
      r = 2'h3;
      @(posedge sys_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (int i = 0; i < 200; i++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
      end
      hang_count++;
      {s_axi_arvalid, s_axi_rready} <= 2'h0;
   endtask
endmodule // dtx_axi_master

// ==== verification/data_transfer_instr_exec_test.sv ====
// Self-checking bench: instruction sequences issued over the register port.
// Assumes the executor and the master model share one 100 MHz clock.
`timescale 1ns/1ps
module data_transfer_instr_exec_test import dtx_pkg::*; ;
   logic              sys_clk = 1'b0;
   logic              rst_n   = 1'b0;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int                bad_count   = 0;
   int                check_count = 0;
   logic [3:0]        flg = 4'h0;
   logic [31:0]       rv, t1;
   logic [1:0]        rsp;

   always #5 sys_clk = ~sys_clk;

   dtx_exec i_dtx_exec (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   dtx_axi_master i_dtx_axi_master (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_rd(input logic [AXI_AW-1:0] a, output logic [31:0] d);
      logic [1:0] r;
      i_dtx_axi_master.rd(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask

   task automatic reg_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [1:0] r;
      i_dtx_axi_master.wr(a, d, s, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask

   // Accumulator, flags, busy and error seen in the status word
   task automatic st(input logic [7:0] acc, input logic err);
      logic [31:0] d;
      reg_rd(REG_STAT, d);
      chk(32'({d[17:16], d[11:0]}), 32'({err, 1'b0, flg, acc}));
   endtask

   // Issue one instruction and wait for it to finish
   task automatic cmd(input logic [3:0] op, input logic [7:0] a, input logic [7:0] imm,
                      input logic [2:0] b = 3'h0);
      dtx_cmd_t c;
      logic [31:0] d;
      c       = '0;
      c.op    = op;
      c.addr  = a;
      c.imm   = imm;
      c.bitn  = b;
      d       = 32'h0001_0000;
      reg_wr(REG_CMD, 32'(c), 4'hf);
      for (int i = 0; i < 20 && d[STAT_BUSY] !== 1'b0; i++) reg_rd(REG_STAT, d);
      chk(32'(d[STAT_BUSY]), 32'h0);
   endtask

   task automatic ld(input logic [7:0] a, input logic [7:0] exp);
      cmd(OP_MOV_AM, a, 8'h00);
      flg[0] = (exp == 8'h00);
      st(exp, 1'b0);
   endtask

   task automatic put(input logic [7:0] a, input logic [7:0] v);
      cmd(OP_MOV_AI, 8'h00, v);
      cmd(OP_MOV_MA, a, 8'h00);
   endtask

   task automatic clr_err(input logic [7:0] acc);
      reg_wr(REG_STAT, 32'h0002_0000, 4'h4);
      st(acc, 1'b0);
   endtask

   task automatic give_verdict;
      bad_count += i_dtx_axi_master.hang_count;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      st(8'h00, 1'b0);
      reg_rd(REG_SP, rv);
      chk(rv, 32'(SP_RST));
      reg_rd(REG_TMR, rv);
      chk(rv, 32'h0);
      $display("test reset done");
      ld(8'h03, 8'h00);
      cmd(OP_MOV_AI, 8'h00, 8'h5b);
      st(8'h5b, 1'b0);
      cmd(OP_MOV_MA, 8'h03, 8'h00);
      st(8'h5b, 1'b0);
      cmd(OP_MOV_AI, 8'h00, 8'h00);
      ld(8'h03, 8'h5b);
      cmd(OP_MOV_IOA, 8'h02, 8'h00);
      st(8'h5b, 1'b0);
      cmd(OP_MOV_AI, 8'h00, 8'h00);
      cmd(OP_MOV_AIO, 8'h02, 8'h00);
      st(8'h5b, 1'b0);
      cmd(OP_MOV_AIO, 8'h03, 8'h00);
      flg[0] = 1'b1;
      st(8'h00, 1'b0);
      $display("test moves done");
      reg_wr(REG_SP, 32'h10, 4'h1);
      put(8'h13, 8'h0f);
      put(8'h12, 8'h66);
      reg_wr(REG_SP, 32'h14, 4'h1);
      cmd(OP_POP, 8'h00, 8'h00);
      flg = 4'hf;
      st(8'h66, 1'b0);
      reg_rd(REG_SP, rv);
      chk(rv, 32'h12);
      cmd(OP_MOV_AI, 8'h00, 8'h00);
      st(8'h00, 1'b0);
      ld(8'h12, 8'h66);
      cmd(OP_PUSH, 8'h00, 8'h00);
      reg_rd(REG_SP, rv);
      chk(rv, 32'h14);
      ld(8'h13, 8'h0e);
      $display("test stack done");
      put(8'h04, 8'h34);
      put(8'h05, 8'h12);
      cmd(OP_TWR, 8'h04, 8'h00);
      st(8'h12, 1'b0);
      reg_rd(REG_TMR, rv);
      chk(rv, 32'h1234);
      cmd(OP_MOV_AI, 8'h00, 8'h20);
      cmd(OP_MOV_IOA, 8'(IO_TMODE), 8'h00);
      repeat (50) @(posedge sys_clk);
      cmd(OP_MOV_AI, 8'h00, 8'h00);
      cmd(OP_MOV_IOA, 8'(IO_TMODE), 8'h00);
      reg_rd(REG_TMR, t1);
      chk(32'(t1 > 32'h1254), 32'h1);
      repeat (10) @(posedge sys_clk);
      reg_rd(REG_TMR, rv);
      chk(rv, t1);
      cmd(OP_TRD, WORD_MAX - 8'h01, 8'h00);
      ld(8'h1e, t1[7:0]);
      ld(8'h1f, t1[15:8]);
      $display("test timer done");
      cmd(OP_TWR, 8'h20, 8'h00);
      st(t1[15:8], 1'b1);
      reg_rd(REG_TMR, rv);
      chk(rv, t1);
      clr_err(t1[15:8]);
      cmd(OP_SET1, BIT_MAX + 8'h01, 8'h00, 3'h0);
      st(t1[15:8], 1'b1);
      clr_err(t1[15:8]);
      cmd(OP_SET1, BIT_MAX, 8'h00, 3'h7);
      ld(BIT_MAX, 8'h80);
      cmd(OP_SET0, BIT_MAX, 8'h00, 3'h7);
      ld(BIT_MAX, 8'h00);
      cmd(4'he, 8'h00, 8'h00);
      st(8'h00, 1'b1);
      clr_err(8'h00);
      cmd(OP_NOP, 8'h00, 8'h00);
      st(8'h00, 1'b0);
      cmd(OP_TRD, 8'h05, 8'h00);
      st(8'h00, 1'b1);
      clr_err(8'h00);
      i_dtx_axi_master.rd(4'h2, rv, rsp);
      chk(rv, 32'h0);
      chk(32'(rsp), 32'(RESP_SLV));
      $display("test limits done");
      put(8'h08, 8'h30);
      put(8'h09, 8'h00);
      cmd(OP_MOV_AI, 8'h00, 8'ha5);
      cmd(OP_IDX_ST, 8'h08, 8'h00);
      st(8'ha5, 1'b0);
      ld(8'h30, 8'ha5);
      ld(8'h31, 8'h00);
      cmd(OP_IDX_LD, 8'h08, 8'h00);
      st(8'ha5, 1'b0);
      $display("test indirect done");
      give_verdict();
   end
endmodule // data_transfer_instr_exec_test
